/* File: hw/rtca_alarm_cmp.sv */
// Purpose: Compares live calendar time against the alarm set-point
// Assumes: Live time comes from logic on clk_sys
// Notes:   Match is registered, one cycle behind its inputs
module rtca_alarm_cmp (
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	input  wire rtca_pkg::rtca_time_s live_time,
	input  wire rtca_pkg::rtca_time_s alarm_time,
	input  wire logic                twelve_hour_format,
	output logic                     match_q
);

	rtca_pkg::rtca_time_s live_m;
	rtca_pkg::rtca_time_s alarm_m;
	logic                 match_d;

	// ----------------------------------------------------------------
	// Mode-aware compare
	// ----------------------------------------------------------------
	// PM is ignored in 24-hour mode so a stale flag cannot block a match
	always_comb begin
		live_m     = live_time;
		alarm_m    = alarm_time;
		live_m.pm  = live_time.pm & twelve_hour_format;
		alarm_m.pm = alarm_time.pm & twelve_hour_format;
	end

	assign match_d = (live_m == alarm_m);

	// Registered to cut the wide compare path
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match_d;
		end
	end

endmodule : rtca_alarm_cmp

/* File: hw/rtca_alarm_regs.sv */
// Purpose: Alarm set-point and weekday registers of the calendar clock
// Assumes: Register port driven by the control-bus engine on clk_sys
// Notes:   Read data valid one cycle after the read strobe
module rtca_alarm_regs (
	input  wire logic                clk_sys,
	input  wire logic                reset_n,
	input  wire rtca_pkg::rtca_req_s reg_req,
	input  wire rtca_pkg::rtca_time_s live_time,
	input  wire logic                twelve_hour_format,
	output logic [7:0]               rd_data_q,
	output logic                     rd_valid_q,
	output logic [2:0]               weekday_q,
	output logic                     alarm_hit_q
);

`include "rtca_defines.svh"

	logic                 rst_n_sync;
	logic [6:0]           sec_q;
	logic [6:0]           min_q;
	logic [5:0]           hr_q;
	logic                 pm_q;
	logic [5:0]           day_q;
	logic [4:0]           mon_q;
	logic [7:0]           yr_q;
	logic                 pm_d;
	logic                 match_q;
	logic                 match_d1_q;
	logic [7:0]           wmask;
	logic [7:0]           rd_mux;
	rtca_pkg::rtca_time_s alarm_time;
	logic                 a_week;
	logic                 a_sec;
	logic                 a_min;
	logic                 a_hr;
	logic                 a_day;
	logic                 a_mon;
	logic                 a_yr;
	logic                 a_any;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	rtca_rst_sync u_rtca_rst_sync (
		.clk_sys    (clk_sys),
		.reset_n    (reset_n),
		.rst_n_sync (rst_n_sync)
	);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Shared by the write enables and the read mux
	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
		addr_is = (addr == ofs);
	endfunction : addr_is

	assign a_week = addr_is(reg_req.addr, `RTCA_OFS_WEEK);
	assign a_sec  = addr_is(reg_req.addr, `RTCA_OFS_ALM_SEC);
	assign a_min  = addr_is(reg_req.addr, `RTCA_OFS_ALM_MIN);
	assign a_hr   = addr_is(reg_req.addr, `RTCA_OFS_ALM_HR);
	assign a_day  = addr_is(reg_req.addr, `RTCA_OFS_ALM_DAY);
	assign a_mon  = addr_is(reg_req.addr, `RTCA_OFS_ALM_MON);
	assign a_yr   = addr_is(reg_req.addr, `RTCA_OFS_ALM_YR);
	assign a_any  = a_week | a_sec | a_min | a_hr | a_day | a_mon | a_yr;

	// Reserved bits never reach a flop, so they read back as zero
	assign wmask = ({8{a_week}} & `RTCA_MSK_WEEK)
	             | ({8{a_sec}}  & `RTCA_MSK_SEC)
	             | ({8{a_min}}  & `RTCA_MSK_MIN)
	             | ({8{a_hr}}   & `RTCA_MSK_HR)
	             | ({8{a_day}}  & `RTCA_MSK_DAY)
	             | ({8{a_mon}}  & `RTCA_MSK_MON)
	             | ({8{a_yr}}   & `RTCA_MSK_YR);

	// ----------------------------------------------------------------
	// PM flag next value
	// ----------------------------------------------------------------
	// Forced to zero in 24-hour mode, even when software writes a one
	assign pm_d = !twelve_hour_format ? 1'b0 :
	              (reg_req.wr && a_hr) ? reg_req.wdata[`RTCA_POS_PM] : pm_q;

	// ----------------------------------------------------------------
	// Set-point and weekday registers
	// ----------------------------------------------------------------
	// Range checks are left to software; digits are stored as written
	always_ff @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			weekday_q <= 3'h0;
			sec_q     <= 7'h00;
			min_q     <= 7'h00;
			hr_q      <= 6'h00;
			pm_q      <= 1'b0;
			day_q     <= 6'(`RTCA_RST_DAY);
			mon_q     <= 5'(`RTCA_RST_MON);
			yr_q      <= `RTCA_RST_ZERO;
		end else begin
			pm_q <= pm_d;
			if (reg_req.wr && a_week) begin
				weekday_q <= reg_req.wdata[2:0];
			end
			if (reg_req.wr && a_sec) begin
				sec_q <= reg_req.wdata[6:0];
			end
			if (reg_req.wr && a_min) begin
				min_q <= reg_req.wdata[6:0];
			end
			if (reg_req.wr && a_hr) begin
				hr_q <= reg_req.wdata[5:0];
			end
			if (reg_req.wr && a_day) begin
				day_q <= reg_req.wdata[5:0];
			end
			if (reg_req.wr && a_mon) begin
				mon_q <= reg_req.wdata[4:0];
			end
			if (reg_req.wr && a_yr) begin
				yr_q <= reg_req.wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Unmapped offsets read as zero; reserved bits are zero-filled
	assign rd_mux = (({8{a_week}} & {5'h00, weekday_q})
	              |  ({8{a_sec}}  & {1'b0, sec_q})
	              |  ({8{a_min}}  & {1'b0, min_q})
	              |  ({8{a_hr}}   & {pm_q, 1'b0, hr_q})
	              |  ({8{a_day}}  & {2'h0, day_q})
	              |  ({8{a_mon}}  & {3'h0, mon_q})
	              |  ({8{a_yr}}   & yr_q)) & wmask;

	// Data holds until the next read strobe
	always_ff @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			rd_data_q  <= 8'h00;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= reg_req.rd;
			if (reg_req.rd) begin
				rd_data_q <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// Alarm compare
	// ----------------------------------------------------------------
	always_comb begin
		alarm_time     = '0;
		alarm_time.yr  = yr_q;
		alarm_time.mon = mon_q;
		alarm_time.day = day_q;
		alarm_time.pm  = pm_q;
		alarm_time.hr  = hr_q;
		alarm_time.min = min_q;
		alarm_time.sec = sec_q;
	end

	rtca_alarm_cmp u_rtca_alarm_cmp (
		.clk_sys            (clk_sys),
		.rst_n              (rst_n_sync),
		.live_time          (live_time),
		.alarm_time         (alarm_time),
		.twelve_hour_format (twelve_hour_format),
		.match_q            (match_q)
	);

	// One pulse per match, so a held time does not refire every cycle
	always_ff @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			match_d1_q  <= 1'b0;
			alarm_hit_q <= 1'b0;
		end else begin
			match_d1_q  <= match_q;
			alarm_hit_q <= match_q & ~match_d1_q;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n_sync);

	week_rsvd_zero_a: assert property (
		rd_valid_q && $past(a_week) |-> rd_data_q[7:3] == 5'h00)
		else $error("weekday reserved bits read nonzero");

	sec_write_a: assert property (
		reg_req.wr && a_sec |=> sec_q == $past(reg_req.wdata[6:0]))
		else $error("alarm seconds not written");

	min_readback_a: assert property (
		reg_req.wr && a_min ##1 !reg_req.wr ##1 reg_req.rd && a_min
		|=> rd_data_q == {1'b0, $past(reg_req.wdata[6:0], 3)})
		else $error("alarm minutes readback wrong");

	pm_hold_a: assert property (
		!twelve_hour_format |=> !pm_q)
		else $error("PM flag set in 24-hour mode");

	pm_set_a: assert property (
		twelve_hour_format && reg_req.wr && a_hr && reg_req.wdata[7] |=> pm_q)
		else $error("PM flag not taken in 12-hour mode");

	hr_rsvd_zero_a: assert property (
		rd_valid_q && $past(a_hr) |-> rd_data_q[6] == 1'b0)
		else $error("hours reserved bit reads nonzero");

	day_rsvd_zero_a: assert property (
		rd_valid_q && $past(a_day) |-> rd_data_q[7:6] == 2'h0)
		else $error("days reserved bits read nonzero");

	date_reset_a: assert property (
		$rose(rst_n_sync) |-> day_q == 6'h01 && mon_q == 5'h01 && sec_q == 7'h00)
		else $error("reset date is not day 01 of January");

	mon_rsvd_zero_a: assert property (
		rd_valid_q && $past(a_mon) |-> rd_data_q[7:5] == 3'h0)
		else $error("months reserved bits read nonzero");

	mon_write_a: assert property (
		reg_req.wr && a_mon |=> mon_q == $past(reg_req.wdata[4:0]))
		else $error("alarm months not written");

	yr_write_a: assert property (
		reg_req.wr && a_yr ##1 !reg_req.wr ##1 reg_req.rd && a_yr
		|=> rd_data_q == $past(reg_req.wdata, 3))
		else $error("alarm years readback wrong");

	unmapped_zero_a: assert property (
		reg_req.rd && !a_any |=> rd_valid_q && rd_data_q == 8'h00)
		else $error("unmapped read not zero");

	alarm_pulse_a: assert property (
		$rose(match_q) |=> alarm_hit_q ##1 !alarm_hit_q)
		else $error("alarm hit not a single pulse");

	alarm_cause_a: assert property (
		alarm_hit_q |-> $past(match_q) && !$past(match_d1_q))
		else $error("alarm hit without a match");

	rd_read_c:   cover property (reg_req.rd && a_sec ##1 rd_valid_q);
	pm_set_c:    cover property (twelve_hour_format && pm_q);
	alarm_hit_c: cover property (alarm_hit_q);
	unmapped_c:  cover property (reg_req.rd && !a_any);

endmodule : rtca_alarm_regs

/* File: hw/rtca_rst_sync.sv */
// Purpose: Asynchronous assert, synchronous release of the block reset
// Assumes: reset_n may change at any time relative to clk_sys
// Notes:   Two flops, the second one feeds the design
module rtca_rst_sync (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	output logic      rst_n_sync
);

	logic meta_q;

	// ----------------------------------------------------------------
	// Release chain
	// ----------------------------------------------------------------
	// Two stages keep release off a metastable edge
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta_q     <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			meta_q     <= 1'b1;
			rst_n_sync <= meta_q;
		end
	end

endmodule : rtca_rst_sync

/* File: inc/rtca_defines.svh */
// Purpose: Offsets, field masks, field positions and reset values of the alarm set-point registers
// Assumes: Byte-wide registers on the control-bus register port
// Notes:   Masks clear reserved bits on read; writes keep only the field widths
`ifndef RTCA_DEFINES_SVH
`define RTCA_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RTCA_OFS_WEEK      8'h06
`define RTCA_OFS_ALM_SEC   8'h08
`define RTCA_OFS_ALM_MIN   8'h09
`define RTCA_OFS_ALM_HR    8'h0A
`define RTCA_OFS_ALM_DAY   8'h0B
`define RTCA_OFS_ALM_MON   8'h0C
`define RTCA_OFS_ALM_YR    8'h0D

// ----------------------------------------------------------------
// Writable-bit masks, reserved bits are zero
// ----------------------------------------------------------------
`define RTCA_MSK_WEEK      8'h07
`define RTCA_MSK_SEC       8'h7F
`define RTCA_MSK_MIN       8'h7F
`define RTCA_MSK_HR        8'hBF
`define RTCA_MSK_DAY       8'h3F
`define RTCA_MSK_MON       8'h1F
`define RTCA_MSK_YR        8'hFF

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define RTCA_POS_PM        7
`define RTCA_RST_ZERO      8'h00
`define RTCA_RST_DAY       8'h01
`define RTCA_RST_MON       8'h01

`endif

/* File: inc/rtca_pkg.sv */
// Purpose: Types shared by the alarm set-point block
// Assumes: Packed BCD digit fields
// Notes:   Time layout is identical for live time and alarm set-point
package rtca_pkg;

	// Calendar time as packed BCD, PM flag separate from hour digits
	typedef struct packed {
		logic [7:0] yr;
		logic [4:0] mon;
		logic [5:0] day;
		logic       pm;
		logic [5:0] hr;
		logic [6:0] min;
		logic [6:0] sec;
	} rtca_time_s;

	// One register access from the control-bus engine
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rtca_req_s;

endpackage : rtca_pkg

/* File: testbench/rtca_host_model.sv */
// Purpose: Host side of the register port, one byte access per call
// Assumes: Strobes change just after a rising edge of clk_sys
// Notes:   Released address and data lines show the inverse of the last value
module rtca_host_model (
	input  wire logic                clk_sys,
	input  wire logic [7:0]          rd_data_q,
	input  wire logic                rd_valid_q,
	output rtca_pkg::rtca_req_s      reg_req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reg_req = '0;
	end

	// ----------------------------------------------------------------
	// Write: strobe for one edge, then release the lines
	// ----------------------------------------------------------------
	task write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : write_reg

	// ----------------------------------------------------------------
	// Read: answer is awaited under a bound, never open-ended
	// ----------------------------------------------------------------
	task read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		int n;
		@(posedge clk_sys);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: reg_req.wdata};
		@(posedge clk_sys);
		reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~reg_req.wdata};
		ok = 1'b0;
		d = 8'hXX;
		for (n = 0; n < 4 && !ok; n++) begin
			#1;
			if (rd_valid_q === 1'b1) begin
				ok = 1'b1;
				d = rd_data_q;
			end else begin
				@(posedge clk_sys);
			end
		end
	endtask : read_reg
endmodule : rtca_host_model

/* File: testbench/tb_rtc_alarm_setpoint_registers.sv */
// Purpose: Self-checking bench of the alarm set-point registers
// Assumes: Host model drives the register port
// Notes:   Expectations come from field layouts, never from the design
module tb_rtc_alarm_setpoint_registers;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 clk_sys;
	logic                 reset_n;
	rtca_pkg::rtca_req_s  reg_req;
	rtca_pkg::rtca_time_s live_time;
	logic                 twelve_hour_format;
	logic [7:0]           rd_data_q;
	logic                 rd_valid_q;
	logic [2:0]           weekday_q;
	logic                 alarm_hit_q;
	int                   miscompares = 0;
	int                   num_checks = 0;

	// Offsets, reset values and writable masks in 24-hour mode
	localparam logic [7:0] ADR[7] = '{8'h06, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
	localparam logic [7:0] RST[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
	localparam logic [7:0] MSK[7] = '{8'h07, 8'h7F, 8'h7F, 8'h3F, 8'h3F, 8'h1F, 8'hFF};

	rtca_alarm_regs u_rtca_alarm_regs (
		.clk_sys            (clk_sys),
		.reset_n            (reset_n),
		.reg_req            (reg_req),
		.live_time          (live_time),
		.twelve_hour_format (twelve_hour_format),
		.rd_data_q          (rd_data_q),
		.rd_valid_q         (rd_valid_q),
		.weekday_q          (weekday_q),
		.alarm_hit_q        (alarm_hit_q)
	);

	rtca_host_model u_rtca_host_model (
		.clk_sys    (clk_sys),
		.rd_data_q  (rd_data_q),
		.rd_valid_q (rd_valid_q),
		.reg_req    (reg_req)
	);

	// ----------------------------------------------------------------
	// Clock, report and shared checks
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task stop_test();
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test

	task check(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// Read with a bounded wait; a lost answer counts and ends the run
	task rd_check(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		u_rtca_host_model.read_reg(a, d, ok);
		if (!ok) begin
			miscompares++;
			$display("mismatch at %0t: no read answer at %h", $time, a);
			stop_test();
		end
		check(d, exp, "read data");
	endtask : rd_check

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task test_reset();
		for (int i = 0; i < 7; i++) begin
			rd_check(ADR[i], RST[i]);
		end
		check({5'h00, weekday_q}, 8'h00, "weekday after reset");
		$display("test reset done");
	endtask : test_reset

	// All ones written, reserved bits and flag outside 12-hour must read zero
	task test_masks();
		for (int i = 0; i < 7; i++) begin
			u_rtca_host_model.write_reg(ADR[i], 8'hFF);
			rd_check(ADR[i], MSK[i]);
		end
		u_rtca_host_model.write_reg(8'h06, 8'hF6);
		rd_check(8'h06, 8'h06);
		check({5'h00, weekday_q}, 8'h06, "weekday level");
		$display("test masks done");
	endtask : test_masks

	// Flag held in 12-hour mode, cleared once 24-hour mode returns
	task test_pm_mode();
		@(posedge clk_sys);
		twelve_hour_format <= 1'b1;
		u_rtca_host_model.write_reg(8'h0A, 8'hFF);
		rd_check(8'h0A, 8'hBF);
		@(posedge clk_sys);
		twelve_hour_format <= 1'b0;
		rd_check(8'h0A, 8'h3F);
		$display("test pm mode done");
	endtask : test_pm_mode

	// Unmapped offsets take no write and read zero
	task test_unmapped();
		u_rtca_host_model.write_reg(8'h07, 8'hA5);
		rd_check(8'h07, 8'h00);
		u_rtca_host_model.write_reg(8'h0E, 8'h5A);
		rd_check(8'h0E, 8'h00);
		$display("test unmapped done");
	endtask : test_unmapped

	// Counts cycles until the alarm pulse, then wants it gone next cycle
	task expect_hit(input logic want);
		int n;
		n = 0;
		while (n < 6 && alarm_hit_q !== 1'b1) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check({7'h00, alarm_hit_q}, {7'h00, want}, "alarm pulse");
		@(posedge clk_sys);
		#1;
		check({7'h00, alarm_hit_q}, 8'h00, "alarm pulse width");
	endtask : expect_hit

	task test_alarm();
		@(posedge clk_sys);
		twelve_hour_format <= 1'b1;
		u_rtca_host_model.write_reg(8'h08, 8'h45);
		u_rtca_host_model.write_reg(8'h09, 8'h30);
		u_rtca_host_model.write_reg(8'h0A, 8'h91);
		u_rtca_host_model.write_reg(8'h0B, 8'h15);
		u_rtca_host_model.write_reg(8'h0C, 8'h11);
		u_rtca_host_model.write_reg(8'h0D, 8'h24);
		// Afternoon flag differs: no alarm in 12-hour mode
		live_time <= '{yr: 8'h24, mon: 5'h11, day: 6'h15, pm: 1'b0,
			hr: 6'h11, min: 7'h30, sec: 7'h45};
		expect_hit(1'b0);
		@(posedge clk_sys);
		live_time.pm <= 1'b1;
		expect_hit(1'b1);
		@(posedge clk_sys);
		live_time.sec <= 7'h46;
		expect_hit(1'b0);
		// 24-hour mode: flags masked on both sides, so the match returns
		@(posedge clk_sys);
		twelve_hour_format <= 1'b0;
		live_time.sec      <= 7'h45;
		expect_hit(1'b1);
		$display("test alarm done");
	endtask : test_alarm

	// ----------------------------------------------------------------
	// Main sequence: reset held four cycles, first access later
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		twelve_hour_format = 1'b0;
		live_time = '0;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		test_reset();
		test_masks();
		test_pm_mode();
		test_unmapped();
		test_alarm();
		stop_test();
	end
endmodule : tb_rtc_alarm_setpoint_registers
